// >>> verilog/cos_pkg.sv
// Purpose: Shared constants and types for the compare output switching block
// Assumes: One module clock, values are signed 32-bit words
// Notes: Mode codes are internal encodings of the configured function
package cos_pkg;
    localparam int VAL_W = 32;
    localparam int PULSE_W = 16;
    localparam logic [PULSE_W-1:0] PULSE_RST = 16'h0000;
    localparam logic [VAL_W-1:0] CMP_RST = 32'h0000_0000;
    localparam logic OUT_RST = 1'b0;
    localparam logic OWNER_SW = 1'b0;
    localparam logic OWNER_CMP = 1'b1;
    localparam logic DIR_UP = 1'b0;
    localparam logic DIR_DN = 1'b1;

    // Reference source selection
    typedef enum logic [1:0] {
        COS_REF_COUNTER,
        COS_REF_POSITION,
        COS_REF_MEASURED
    } cos_ref_t;

    // Compare function of one output
    typedef enum logic [2:0] {
        COS_MODE_UPPER,
        COS_MODE_LOWER,
        COS_MODE_WINDOW,
        COS_MODE_PULSE,
        COS_MODE_SET_UNTIL,
        COS_MODE_NOT_WINDOW
    } cos_mode_t;
endpackage : cos_pkg

// >>> verilog/cos_pulse_timer.sv
// Purpose: Pulse stretcher that holds one output for a configured count
// Assumes: Duration zero means hold until the next count pulse
// Notes: Retrigger while running restarts the count
module cos_pulse_timer #(
    parameter int WIDTH = cos_pkg::PULSE_W
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_fire,
    input wire logic i_count_pulse,
    input wire logic [WIDTH-1:0] i_duration,
    output logic o_active
);
    import cos_pkg::*;

    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;
    logic hold_ff;
    logic nxt_hold;

    // Next count; zero duration latches until the next count pulse
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_hold = hold_ff;
        if (i_fire) begin
            nxt_cnt = i_duration;
            nxt_hold = (i_duration == '0);
        end else begin
            if (cnt_ff != '0) begin
                nxt_cnt = cnt_ff - 1'b1;
            end
            if (i_count_pulse) begin
                nxt_hold = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
            hold_ff <= 1'b0;
        end else if (i_ce) begin
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
        end
    end

    assign o_active = (cnt_ff != '0) || hold_ff;
endmodule : cos_pulse_timer

// >>> verilog/cos_channel.sv
// Purpose: Per-output match and crossing detection with rearm tracking
// Assumes: Reference value and its previous value come from the top
// Notes: Crossing is taken between the previous and present reference
module cos_channel #(
    parameter int VAL_W = cos_pkg::VAL_W
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_step,
    input wire logic i_is_position,
    input wire logic i_dir_cfg,
    input wire logic signed [VAL_W-1:0] i_ref,
    input wire logic signed [VAL_W-1:0] i_ref_prev,
    input wire logic signed [VAL_W-1:0] i_cmp,
    output logic o_hit
);
    import cos_pkg::*;

    logic armed_ff;
    logic nxt_armed;
    logic moving_up;
    logic dir_ok;
    logic reached;

    // Reach test: counter needs equality, position also accepts a crossing
    always_comb begin
        moving_up = (i_ref > i_ref_prev);
        dir_ok = (i_dir_cfg == DIR_UP) ? moving_up : !moving_up;
        if (i_is_position) begin
            reached = (i_dir_cfg == DIR_UP) ? (i_ref_prev < i_cmp && i_ref >= i_cmp)
                                            : (i_ref_prev > i_cmp && i_ref <= i_cmp);
        end else begin
            reached = (i_ref == i_cmp);
        end
        o_hit = i_step && dir_ok && reached && armed_ff;
        nxt_armed = armed_ff;
        if (o_hit) begin
            nxt_armed = 1'b0;
        end else if (i_step && (i_ref != i_cmp)) begin
            nxt_armed = 1'b1;
        end
    end

    // Rearm state; only real value steps count, not loads
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            armed_ff <= 1'b1;
        end else if (i_ce) begin
            armed_ff <= nxt_armed;
        end
    end
endmodule : cos_channel

// >>> verilog/cos_compare_out.sv
// Purpose: Two compare-driven digital outputs with software override
// Assumes: Counter, position and measured values arrive on the module clock
// Notes: Window modes are honoured only under their documented conditions
module cos_compare_out #(
    parameter int VAL_W = cos_pkg::VAL_W,
    parameter int PULSE_W = cos_pkg::PULSE_W
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire cos_pkg::cos_ref_t i_ref_sel,
    input wire logic signed [VAL_W-1:0] i_counter_value,
    input wire logic i_count_pulse,
    input wire logic i_counter_load,
    input wire logic signed [VAL_W-1:0] i_low_limit,
    input wire logic signed [VAL_W-1:0] i_high_limit,
    input wire logic signed [VAL_W-1:0] i_position_value,
    input wire logic i_position_valid,
    input wire logic signed [VAL_W-1:0] i_max_position,
    input wire logic signed [VAL_W-1:0] i_measured_value,
    input wire logic signed [VAL_W-1:0] i_cmp_value_0,
    input wire logic signed [VAL_W-1:0] i_cmp_value_1,
    input wire cos_pkg::cos_mode_t i_mode_a,
    input wire cos_pkg::cos_mode_t i_mode_b,
    input wire logic i_dir_a,
    input wire logic i_dir_b,
    input wire logic [PULSE_W-1:0] i_pulse_len_a,
    input wire logic [PULSE_W-1:0] i_pulse_len_b,
    input wire logic i_output_a_owner_sel,
    input wire logic i_output_b_owner_sel,
    input wire logic i_set_out_a,
    input wire logic i_set_out_b,
    input wire logic i_hit_clr_a,
    input wire logic i_hit_clr_b,
    output logic o_cmp_output_a,
    output logic o_cmp_output_b,
    output logic o_output_state_flag_a,
    output logic o_output_state_flag_b,
    output logic o_compare_hit_flag_a,
    output logic o_compare_hit_flag_b
);
    import cos_pkg::*;

    logic signed [VAL_W-1:0] ref_val;
    logic signed [VAL_W-1:0] ref_prev_ff;
    logic signed [VAL_W-1:0] nxt_ref_prev;
    logic step;
    logic is_pos;
    logic is_meas;
    logic [1:0] set_prev_ff;
    logic [1:0] nxt_set_prev;
    logic [1:0] sum_ff;
    logic [1:0] nxt_sum;
    logic [1:0] out_ff;
    logic [1:0] nxt_out;
    logic [1:0] flag_ff;
    logic [1:0] nxt_flag;
    logic [1:0] hit_ff;
    logic [1:0] nxt_hit;
    logic [1:0] hit;
    logic [1:0] pulse_act;
    logic [1:0] range_on;
    logic win_ok;
    logic in_win;

    // Per-output views of the port pairs
    cos_mode_t mode [2];
    logic owner [2];
    logic dir [2];
    logic set_bit [2];
    logic hit_clr [2];
    logic signed [VAL_W-1:0] cmp [2];
    logic [PULSE_W-1:0] plen [2];

    assign mode[0] = i_mode_a;
    assign mode[1] = i_mode_b;
    assign owner[0] = i_output_a_owner_sel;
    assign owner[1] = i_output_b_owner_sel;
    assign dir[0] = i_dir_a;
    assign dir[1] = i_dir_b;
    assign set_bit[0] = i_set_out_a;
    assign set_bit[1] = i_set_out_b;
    assign hit_clr[0] = i_hit_clr_a;
    assign hit_clr[1] = i_hit_clr_b;
    assign cmp[0] = i_cmp_value_0;
    assign cmp[1] = i_cmp_value_1;
    assign plen[0] = i_pulse_len_a;
    assign plen[1] = i_pulse_len_b;

    // Reference select; a counter step is a count pulse, never a load
    always_comb begin
        is_pos = (i_ref_sel == COS_REF_POSITION);
        is_meas = (i_ref_sel == COS_REF_MEASURED);
        unique case (i_ref_sel)
            COS_REF_COUNTER: begin
                ref_val = i_counter_value;
                step = i_count_pulse && !i_counter_load;
            end
            COS_REF_POSITION: begin
                ref_val = i_position_value;
                step = i_position_valid && (i_position_value != ref_prev_ff);
            end
            default: begin
                ref_val = i_measured_value;
                step = 1'b0;
            end
        endcase
        nxt_ref_prev = ref_val;
    end

    // Window valid only when A is software-owned and value 1 above value 0
    always_comb begin
        win_ok = (i_output_a_owner_sel == OWNER_SW) && (i_cmp_value_1 > i_cmp_value_0);
        in_win = (ref_val >= i_cmp_value_0) && (ref_val <= i_cmp_value_1);
    end

    generate
        for (genvar g = 0; g < 2; g++) begin : g_out
            cos_channel #(
                .VAL_W(VAL_W)
            ) u_chan (
                .i_sys_clk(i_sys_clk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_step(step),
                .i_is_position(is_pos),
                .i_dir_cfg(dir[g]),
                .i_ref(ref_val),
                .i_ref_prev(ref_prev_ff),
                .i_cmp(cmp[g]),
                .o_hit(hit[g])
            );

            cos_pulse_timer #(
                .WIDTH(PULSE_W)
            ) u_pulse (
                .i_sys_clk(i_sys_clk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_fire(hit[g] && mode[g] == COS_MODE_PULSE && !is_meas),
                .i_count_pulse(step),
                .i_duration(plen[g]),
                .o_active(pulse_act[g])
            );

            // Range and window conditions for this output
            always_comb begin
                range_on[g] = 1'b0;
                unique case (mode[g])
                    COS_MODE_UPPER: begin
                        if (is_meas) begin
                            range_on[g] = (ref_val >= cmp[g]);
                        end else if (is_pos) begin
                            range_on[g] = (ref_val >= cmp[g]) && (ref_val <= i_max_position);
                        end else begin
                            range_on[g] = (ref_val >= cmp[g]) && (ref_val <= i_high_limit);
                        end
                    end
                    COS_MODE_LOWER: begin
                        if (is_meas) begin
                            range_on[g] = (ref_val <= cmp[g]);
                        end else if (is_pos) begin
                            range_on[g] = (ref_val >= 0) && (ref_val <= cmp[g]);
                        end else begin
                            range_on[g] = (ref_val >= i_low_limit) && (ref_val <= cmp[g]);
                        end
                    end
                    COS_MODE_WINDOW: begin
                        range_on[g] = (g == 1) && win_ok && in_win;
                    end
                    COS_MODE_NOT_WINDOW: begin
                        range_on[g] = (g == 1) && is_meas && win_ok && !in_win;
                    end
                    default: begin
                        range_on[g] = 1'b0;
                    end
                endcase
            end

            // Next output, set-until-match state and hit flag
            always_comb begin
                nxt_set_prev[g] = set_bit[g];
                nxt_sum[g] = sum_ff[g];
                if (mode[g] == COS_MODE_SET_UNTIL) begin
                    if (set_bit[g] && !set_prev_ff[g]) begin
                        nxt_sum[g] = 1'b1;
                    end
                    if (!set_bit[g] || (hit[g] && !is_meas)) begin
                        nxt_sum[g] = 1'b0;
                    end
                end else begin
                    nxt_sum[g] = 1'b0;
                end
                if (owner[g] == OWNER_SW) begin
                    nxt_out[g] = set_bit[g];
                end else if (mode[g] == COS_MODE_PULSE) begin
                    nxt_out[g] = pulse_act[g] || (hit[g] && !is_meas);
                end else if (mode[g] == COS_MODE_SET_UNTIL) begin
                    nxt_out[g] = nxt_sum[g];
                end else begin
                    nxt_out[g] = range_on[g];
                end
                nxt_flag[g] = nxt_out[g];
                // Set wins over a same-cycle clear
                nxt_hit[g] = hit_ff[g] && !hit_clr[g];
                if (hit[g] && !is_meas) begin
                    nxt_hit[g] = 1'b1;
                end
            end
        end
    endgenerate

    // Registers; output and its feedback bit update together
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_prev_ff <= CMP_RST;
            set_prev_ff <= '0;
            sum_ff <= '0;
            out_ff <= {2{OUT_RST}};
            flag_ff <= {2{OUT_RST}};
            hit_ff <= '0;
        end else if (i_ce) begin
            ref_prev_ff <= nxt_ref_prev;
            set_prev_ff <= nxt_set_prev;
            sum_ff <= nxt_sum;
            out_ff <= nxt_out;
            flag_ff <= nxt_flag;
            hit_ff <= nxt_hit;
        end
    end

    assign o_cmp_output_a = out_ff[0];
    assign o_cmp_output_b = out_ff[1];
    assign o_output_state_flag_a = flag_ff[0];
    assign o_output_state_flag_b = flag_ff[1];
    assign o_compare_hit_flag_a = hit_ff[0];
    assign o_compare_hit_flag_b = hit_ff[1];
endmodule : cos_compare_out

// >>> bench/cos_compare_out_props.sv
// Purpose: Port-level checks of the compare output switching block
// Assumes: Single clock, asynchronous active-high reset
// Notes: Relations other than flag_tracks_a hold one sampled edge after their cause
module cos_compare_out_props
    import cos_pkg::*;
#(
    parameter int VAL_W = cos_pkg::VAL_W,
    parameter int PULSE_W = cos_pkg::PULSE_W
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire cos_pkg::cos_ref_t i_ref_sel,
    input wire logic signed [VAL_W-1:0] i_counter_value,
    input wire logic i_counter_load,
    input wire logic signed [VAL_W-1:0] i_low_limit,
    input wire logic signed [VAL_W-1:0] i_high_limit,
    input wire logic signed [VAL_W-1:0] i_measured_value,
    input wire logic signed [VAL_W-1:0] i_cmp_value_0,
    input wire logic signed [VAL_W-1:0] i_cmp_value_1,
    input wire cos_pkg::cos_mode_t i_mode_a,
    input wire cos_pkg::cos_mode_t i_mode_b,
    input wire logic i_output_a_owner_sel,
    input wire logic i_output_b_owner_sel,
    input wire logic i_set_out_a,
    input wire logic i_hit_clr_a,
    input wire logic o_cmp_output_a,
    input wire logic o_cmp_output_b,
    input wire logic o_output_state_flag_a,
    input wire logic o_compare_hit_flag_a
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Shorthands for the enabled compare paths
    wire logic cnt_a = i_ce && i_output_a_owner_sel && i_ref_sel == COS_REF_COUNTER;
    wire logic cnt_b = i_ce && i_output_b_owner_sel && i_ref_sel == COS_REF_COUNTER;

    flag_tracks_a: assert property (o_output_state_flag_a == o_cmp_output_a)
        else $error("state flag differs from output a");
    sw_drive_a: assert property (i_ce && !i_output_a_owner_sel |=> o_cmp_output_a == $past(i_set_out_a))
        else $error("software owned output a not following set bit");
    ctr_upper_a: assert property (cnt_a && i_mode_a == COS_MODE_UPPER |=> o_cmp_output_a ==
        ($past(i_counter_value) >= $past(i_cmp_value_0) && $past(i_counter_value) <= $past(i_high_limit)))
        else $error("upper range output a wrong");
    ctr_lower_b: assert property (cnt_b && i_mode_b == COS_MODE_LOWER |=> o_cmp_output_b ==
        ($past(i_counter_value) >= $past(i_low_limit) && $past(i_counter_value) <= $past(i_cmp_value_1)))
        else $error("lower range output b wrong");
    win_refused_b: assert property (i_ce && i_output_b_owner_sel && i_mode_b == COS_MODE_WINDOW &&
        (i_output_a_owner_sel || i_cmp_value_1 <= i_cmp_value_0) |=> !o_cmp_output_b)
        else $error("window mode active when not allowed");
    meas_above_a: assert property (i_ce && i_output_a_owner_sel && i_ref_sel == COS_REF_MEASURED &&
        i_mode_a == COS_MODE_UPPER |=> o_cmp_output_a == ($past(i_measured_value) >= $past(i_cmp_value_0)))
        else $error("measured above output a wrong");
    load_quiet_a: assert property (cnt_a && i_mode_a == COS_MODE_PULSE && i_counter_load &&
        !o_cmp_output_a |=> !o_cmp_output_a)
        else $error("counter load switched pulse output");
    hit_sticky_a: assert property (o_compare_hit_flag_a && !i_hit_clr_a |=> o_compare_hit_flag_a)
        else $error("hit flag a dropped without clear");
    // Main scenarios reached
    cover property (i_mode_a == COS_MODE_PULSE && o_cmp_output_a);
    cover property (i_mode_b == COS_MODE_WINDOW && o_cmp_output_b);
    cover property (i_mode_a == COS_MODE_SET_UNTIL && $fell(o_cmp_output_a));
endmodule : cos_compare_out_props

bind cos_compare_out cos_compare_out_props #(.VAL_W(VAL_W), .PULSE_W(PULSE_W)) u_props (.*);

// >>> bench/cos_ctr_model.sv
// Purpose: Counter core stand-in that steps or loads the counter value
// Assumes: Caller sits just after a falling edge
// Notes: Direction is implied by the new value against the old one
module cos_ctr_model (
    input wire logic i_sys_clk,
    output logic signed [cos_pkg::VAL_W-1:0] o_counter_value,
    output logic o_count_pulse,
    output logic o_counter_load
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_counter_value = 0;
        o_count_pulse = 1'b0;
        o_counter_load = 1'b0;
    end
    // One-cycle step or load, value held afterwards
    task automatic drive(input int v, input logic ld);
        @(negedge i_sys_clk);
        o_counter_value = v;
        o_count_pulse = !ld;
        o_counter_load = ld;
        @(negedge i_sys_clk);
        o_count_pulse = 1'b0;
        o_counter_load = 1'b0;
    endtask : drive
endmodule : cos_ctr_model

// >>> bench/test_compare_output_switching.sv
// Purpose: Directed run of the compare output switching block
// Assumes: Inputs change on falling edges, outputs read there too
// Notes: Five control inputs stay tied to keep the run short
module test_compare_output_switching;
    timeunit 1ns;
    timeprecision 1ns;
    import cos_pkg::*;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_position_valid = 1'b1;
    logic i_counter_load, i_count_pulse, i_dir_a, i_dir_b = 1'b0, i_hit_clr_a, i_hit_clr_b = 1'b0;
    logic signed [VAL_W-1:0] i_counter_value, i_low_limit, i_high_limit, i_position_value;
    logic signed [VAL_W-1:0] i_max_position, i_measured_value, i_cmp_value_0, i_cmp_value_1;
    cos_ref_t i_ref_sel;
    cos_mode_t i_mode_a, i_mode_b;
    logic i_output_a_owner_sel, i_output_b_owner_sel, i_set_out_a, i_set_out_b;
    logic [PULSE_W-1:0] i_pulse_len_a, i_pulse_len_b = 16'h0000;
    logic o_cmp_output_a, o_cmp_output_b, o_output_state_flag_a, o_output_state_flag_b;
    logic o_compare_hit_flag_a, o_compare_hit_flag_b;
    int miscompares = 0, checks = 0;
    int vals[7] = '{4, 5, 10, 11, -1, -2, 3};
    int wv[4] = '{1, 2, 6, 7};

    always #20 i_sys_clk = ~i_sys_clk;
    cos_compare_out uut (.*);
    cos_ctr_model m (.i_sys_clk(i_sys_clk), .o_counter_value(i_counter_value),
        .o_count_pulse(i_count_pulse), .o_counter_load(i_counter_load));

    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t output mismatch", $time);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : tick
    task automatic final_report();
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // Watchdog well beyond the roughly 130 cycles needed
    initial begin
        #100us;
        miscompares++;
        final_report();
    end

    initial begin
        i_ref_sel = COS_REF_COUNTER;
        i_mode_a = COS_MODE_UPPER;
        i_mode_b = COS_MODE_LOWER;
        i_dir_a = DIR_UP;
        i_output_a_owner_sel = OWNER_SW;
        i_output_b_owner_sel = OWNER_SW;
        i_set_out_a = 1'b0;
        i_set_out_b = 1'b1;
        i_hit_clr_a = 1'b0;
        i_pulse_len_a = 16'h0002;
        i_low_limit = -2;
        i_high_limit = 10;
        i_max_position = 10;
        i_position_value = 0;
        i_measured_value = 0;
        i_cmp_value_0 = 5;
        i_cmp_value_1 = 3;
        tick(4);
        chk(o_cmp_output_b, OUT_RST);
        i_rst = 1'b0;
        // Software ownership and state feedback
        tick(2);
        chk(o_cmp_output_b, 1'b1);
        chk(o_output_state_flag_b, 1'b1);
        i_set_out_b = 1'b0;
        i_output_a_owner_sel = OWNER_CMP;
        i_output_b_owner_sel = OWNER_CMP;
        // Range modes, counter then signed position
        for (int r = 0; r < 2; r++) begin
            i_ref_sel = r ? COS_REF_POSITION : COS_REF_COUNTER;
            foreach (vals[k]) begin
                i_position_value = vals[k];
                m.drive(vals[k], 1'b1);
                tick(1);
                chk(o_cmp_output_a, vals[k] >= 5 && vals[k] <= 10);
                chk(o_cmp_output_b, vals[k] >= (r ? 0 : -2) && vals[k] <= 3);
            end
        end
        // Windows need A under software and cmp1 above cmp0
        i_output_a_owner_sel = OWNER_SW;
        i_cmp_value_0 = 2;
        i_cmp_value_1 = 6;
        for (int r = 0; r < 3; r++) begin
            i_ref_sel = cos_ref_t'(r);
            i_mode_b = (r == 2) ? COS_MODE_NOT_WINDOW : COS_MODE_WINDOW;
            foreach (wv[k]) begin
                i_position_value = wv[k];
                i_measured_value = wv[k];
                m.drive(wv[k], 1'b1);
                tick(1);
                chk(o_cmp_output_b, (r == 2) ^ (wv[k] >= 2 && wv[k] <= 6));
            end
        end
        // Window refused once A is compare owned
        i_output_a_owner_sel = OWNER_CMP;
        i_mode_b = COS_MODE_WINDOW;
        i_measured_value = 4;
        tick(3);
        chk(o_cmp_output_b, 1'b0);
        chk(o_cmp_output_a, 1'b1);
        // Pulse on upward match, length 2, then zero-length hold
        i_ref_sel = COS_REF_COUNTER;
        i_mode_a = COS_MODE_PULSE;
        i_cmp_value_0 = 5;
        m.drive(4, 1'b1);
        i_hit_clr_a = 1'b1;
        tick(1);
        i_hit_clr_a = 1'b0;
        m.drive(5, 1'b0);
        chk(o_cmp_output_a, 1'b1);
        chk(o_compare_hit_flag_a, 1'b1);
        tick(2);
        chk(o_cmp_output_a, 1'b1);
        tick(1);
        chk(o_cmp_output_a, 1'b0);
        m.drive(5, 1'b1);
        tick(2);
        chk(o_cmp_output_a, 1'b0);
        m.drive(6, 1'b1);
        m.drive(5, 1'b0);
        tick(1);
        chk(o_cmp_output_a, 1'b0);
        i_pulse_len_a = 16'h0000;
        m.drive(4, 1'b0);
        m.drive(5, 1'b0);
        tick(4);
        chk(o_cmp_output_a, 1'b1);
        m.drive(6, 1'b0);
        tick(1);
        chk(o_cmp_output_a, 1'b0);
        // Set until match, then hit with set bit low
        i_mode_a = COS_MODE_SET_UNTIL;
        m.drive(3, 1'b1);
        i_set_out_a = 1'b1;
        tick(2);
        chk(o_cmp_output_a, 1'b1);
        m.drive(4, 1'b0);
        m.drive(5, 1'b0);
        tick(1);
        chk(o_cmp_output_a, 1'b0);
        i_set_out_a = 1'b0;
        i_hit_clr_a = 1'b1;
        m.drive(4, 1'b0);
        i_hit_clr_a = 1'b0;
        m.drive(5, 1'b0);
        tick(1);
        chk(o_compare_hit_flag_a, 1'b1);
        chk(o_compare_hit_flag_b, 1'b1);
        final_report();
    end
endmodule : test_compare_output_switching
